// File: rtl/mag_readout.sv
// register readout logic of a three-axis magnetic sensor.
// assumes a same-clock register port and a same-clock sensing front end
// that pulses meas_begin at measurement start and meas_done with a result.
//
// Function
// - reset returns every register to initial value
// - offset zero reads fixed identity byte
// - result ready flag set in single/self-test
// - ready flag cleared by status two/data read
// - skipped flag set in continuous/trigger modes
// - skipped flag cleared by status two/data read
// - axis words little endian from 03H, reset zero
// - results signed two's complement, low first
// - 16-bit results clamped to plus/minus 32760
// - sensor overflow flag in status two bit3
// - overflow flag cleared when measurement begins
// - status two bit4 mirrors width setting
// - streaming-mode data read opens session until status two
// - mode field low four bits, listed codes
// - width bit selects 14 or 16 bit
// - control one write clears 02H to 08H and 09H bit3
// - soft reset initialises all, bit self-clears
`timescale 1ns/10ps

module mag_readout #(
  parameter logic [7:0] IDENTITY = 8'h5a, // arbitrary value
  parameter logic [7:0] DETAILS  = 8'h00, // arbitrary value
  parameter logic [7:0] X_TRIM   = 8'h80,
  parameter logic [7:0] Y_TRIM   = 8'h80,
  parameter logic [7:0] Z_TRIM   = 8'h80
) (
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rstn,
  // register port
  input  wire logic [4:0]           reg_addr,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  input  wire logic [7:0]           reg_wdata,
  output logic      [7:0]           reg_rdata,
  output logic                      reg_rvalid,
  // sensing front end
  input  wire logic                 meas_begin,
  input  wire logic                 meas_done,
  input  wire mag_readout_pkg::meas_s meas_in,
  output logic      [3:0]           op_mode,
  output logic                      wide_output,
  output logic                      selftest_on
);

  // clamp to the range of the selected width
  function automatic logic [15:0] clamp(input logic [15:0] v,
                                        input logic        wide);
    logic signed [15:0] hi;
    logic signed [15:0] lo;
    hi = wide ? mag_readout_pkg::MAX_16 : mag_readout_pkg::MAX_14;
    lo = wide ? mag_readout_pkg::MIN_16 : mag_readout_pkg::MIN_14;
    if ($signed(v) > hi) begin
      clamp = hi;
    end else if ($signed(v) < lo) begin
      clamp = lo;
    end else begin
      clamp = v;
    end
  endfunction

  function automatic logic is_streaming(input logic [3:0] m);
    is_streaming = (m == mag_readout_pkg::MODE_CONT1) ||
                   (m == mag_readout_pkg::MODE_CONT2) ||
                   (m == mag_readout_pkg::MODE_TRIG);
  endfunction

  function automatic logic is_data(input logic [4:0] a);
    is_data = (a >= mag_readout_pkg::OFS_XLOW) &&
              (a <= mag_readout_pkg::OFS_ZHIGH);
  endfunction

  // only these two modes report through the ready flag
  function automatic logic sets_ready(input logic [3:0] m);
    sets_ready = (m == mag_readout_pkg::MODE_SINGLE) ||
                 (m == mag_readout_pkg::MODE_SELF);
  endfunction

  // little-endian byte of an axis word
  function automatic logic [7:0] word_byte(input logic [15:0] w,
                                           input logic        upper);
    word_byte = upper ? w[15:8] : w[7:0];
  endfunction

  logic [7:0]  control_one_q;
  logic [7:0]  selftest_q;
  logic [7:0]  port_dis_q;
  logic        ready_q;
  logic        skipped_q;
  logic        overflow_q;
  logic        session_q;
  logic [15:0] x_q;
  logic [15:0] y_q;
  logic [15:0] z_q;
  logic [7:0]  rdata_d;

  logic [3:0]  mode;
  logic        soft_reset;
  logic        reinit;
  logic        rd_data;
  logic        rd_status2;
  logic        flag_clear;
  logic        blocked;
  logic        accept;
  logic        skip;
  logic        wide;
  logic        wr_control1;
  logic        wr_selftest;
  logic        wr_port_dis;
  logic        set_ready;
  logic        set_overflow;

  assign mode       = control_one_q[mag_readout_pkg::MODE_MSB:0];
  assign soft_reset = reg_wr &&
                      (reg_addr == mag_readout_pkg::OFS_CONTROL2) &&
                      reg_wdata[mag_readout_pkg::SOFT_RESET_BIT];
  assign wr_control1 = reg_wr &&
                       (reg_addr == mag_readout_pkg::OFS_CONTROL1);
  assign wr_selftest = reg_wr &&
                       (reg_addr == mag_readout_pkg::OFS_SELFTEST);
  assign wr_port_dis = reg_wr &&
                       (reg_addr == mag_readout_pkg::OFS_PORT_DIS);
  assign reinit     = soft_reset || wr_control1;
  assign rd_data    = reg_rd && is_data(reg_addr);
  assign rd_status2 = reg_rd && (reg_addr == mag_readout_pkg::OFS_STATUS2);
  assign flag_clear = rd_data || rd_status2;
  // a data read this cycle already froze the old bytes, so block too
  assign blocked    = session_q || (rd_data && is_streaming(mode));
  assign accept     = meas_done && !blocked;
  assign skip       = meas_done && blocked && is_streaming(mode);
  assign set_ready  = accept && sets_ready(mode);
  assign set_overflow = accept && meas_in.overflow;
  assign wide       = control_one_q[mag_readout_pkg::WIDTH_BIT];

  // control one; soft reset restores it, the bit itself never stored
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      control_one_q <= mag_readout_pkg::BYTE_RESET;
    end else if (soft_reset) begin
      control_one_q <= mag_readout_pkg::BYTE_RESET;
    end else if (wr_control1) begin
      control_one_q <= {3'b000,
                        reg_wdata[mag_readout_pkg::WIDTH_BIT:0]};
    end
  end

  // self-test control keeps all eight bits
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      selftest_q <= mag_readout_pkg::BYTE_RESET;
    end else if (soft_reset) begin
      selftest_q <= mag_readout_pkg::BYTE_RESET;
    end else if (wr_selftest) begin
      selftest_q <= reg_wdata;
    end
  end

  // port disable; once the key is in, locked until a reset
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      port_dis_q <= mag_readout_pkg::BYTE_RESET;
    end else if (soft_reset) begin
      port_dis_q <= mag_readout_pkg::BYTE_RESET;
    end else if (wr_port_dis &&
                 (port_dis_q != mag_readout_pkg::PORT_DIS_KEY)) begin
      port_dis_q <= reg_wdata;
    end
  end

  // reading session of streaming modes
  // single mode reads never lock, so a new result always lands there
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      session_q <= 1'b0;
    end else if (reinit || rd_status2) begin
      session_q <= 1'b0;
    end else if (rd_data && is_streaming(mode)) begin
      session_q <= 1'b1;
    end
  end

  // status flags; in the same cycle reinit wins over a new event, and a new event wins over a read or measurement-start clear
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ready_q <= 1'b0;
    end else if (reinit) begin
      ready_q <= 1'b0;
    end else if (set_ready) begin
      ready_q <= 1'b1;
    end else if (flag_clear) begin
      ready_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      skipped_q <= 1'b0;
    end else if (reinit) begin
      skipped_q <= 1'b0;
    end else if (skip) begin
      skipped_q <= 1'b1;
    end else if (flag_clear) begin
      skipped_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      overflow_q <= 1'b0;
    end else if (reinit) begin
      overflow_q <= 1'b0;
    end else if (set_overflow) begin
      overflow_q <= 1'b1;
    end else if (meas_begin) begin
      overflow_q <= 1'b0;
    end
  end

  // measurement words
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      x_q <= {2{mag_readout_pkg::BYTE_RESET}};
      y_q <= {2{mag_readout_pkg::BYTE_RESET}};
      z_q <= {2{mag_readout_pkg::BYTE_RESET}};
    end else if (reinit) begin
      x_q <= {2{mag_readout_pkg::BYTE_RESET}};
      y_q <= {2{mag_readout_pkg::BYTE_RESET}};
      z_q <= {2{mag_readout_pkg::BYTE_RESET}};
    end else if (accept) begin
      // results dropped in a frozen session only show up as skip
      x_q <= clamp(meas_in.x, wide);
      y_q <= clamp(meas_in.y, wide);
      z_q <= clamp(meas_in.z, wide);
    end
  end

  // read data mux; trim bytes are only meaningful in fuse access mode
  always_comb begin
    rdata_d = mag_readout_pkg::BYTE_RESET;
    if (reg_addr == mag_readout_pkg::OFS_IDENTITY) begin
      rdata_d = IDENTITY;
    end else if (reg_addr == mag_readout_pkg::OFS_DETAILS) begin
      rdata_d = DETAILS;
    end else if (reg_addr == mag_readout_pkg::OFS_STATUS1) begin
      rdata_d[mag_readout_pkg::RDY_BIT]  = ready_q;
      rdata_d[mag_readout_pkg::SKIP_BIT] = skipped_q;
    end else if (reg_addr == mag_readout_pkg::OFS_XLOW) begin
      rdata_d = word_byte(x_q, 1'b0);
    end else if (reg_addr == mag_readout_pkg::OFS_XHIGH) begin
      rdata_d = word_byte(x_q, 1'b1);
    end else if (reg_addr == mag_readout_pkg::OFS_YLOW) begin
      rdata_d = word_byte(y_q, 1'b0);
    end else if (reg_addr == mag_readout_pkg::OFS_YHIGH) begin
      rdata_d = word_byte(y_q, 1'b1);
    end else if (reg_addr == mag_readout_pkg::OFS_ZLOW) begin
      rdata_d = word_byte(z_q, 1'b0);
    end else if (reg_addr == mag_readout_pkg::OFS_ZHIGH) begin
      rdata_d = word_byte(z_q, 1'b1);
    end else if (reg_addr == mag_readout_pkg::OFS_STATUS2) begin
      rdata_d[mag_readout_pkg::OVF_BIT]   = overflow_q;
      rdata_d[mag_readout_pkg::WIDTH_BIT] =
        control_one_q[mag_readout_pkg::WIDTH_BIT];
    end else if (reg_addr == mag_readout_pkg::OFS_CONTROL1) begin
      rdata_d = control_one_q;
    end else if (reg_addr == mag_readout_pkg::OFS_SELFTEST) begin
      rdata_d = selftest_q;
    end else if (reg_addr == mag_readout_pkg::OFS_PORT_DIS) begin
      rdata_d = port_dis_q;
    end else if (mode == mag_readout_pkg::MODE_FUSE) begin
      if (reg_addr == mag_readout_pkg::OFS_XTRIM) begin
        rdata_d = X_TRIM;
      end else if (reg_addr == mag_readout_pkg::OFS_YTRIM) begin
        rdata_d = Y_TRIM;
      end else if (reg_addr == mag_readout_pkg::OFS_ZTRIM) begin
        rdata_d = Z_TRIM;
      end
    end
  end

  // read strobe echoed one cycle later
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
    end
  end

  // control two, factory test and unmapped offsets read as zero
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= mag_readout_pkg::BYTE_RESET;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end
  end

  assign op_mode     = mode;
  assign wide_output = wide;
  assign selftest_on = selftest_q[mag_readout_pkg::SELFTEST_BIT];

endmodule // mag_readout

// File: inc/mag_readout_pkg.sv
// constants, field layout and carrier types of the magnetometer readout.
// assumes a byte-wide register port with a 5-bit register index.
package mag_readout_pkg;

  localparam int ADDR_W = 5;

  // register offsets
  localparam logic [4:0] OFS_IDENTITY  = 5'h00;
  localparam logic [4:0] OFS_DETAILS   = 5'h01;
  localparam logic [4:0] OFS_STATUS1   = 5'h02;
  localparam logic [4:0] OFS_XLOW      = 5'h03;
  localparam logic [4:0] OFS_XHIGH     = 5'h04;
  localparam logic [4:0] OFS_YLOW      = 5'h05;
  localparam logic [4:0] OFS_YHIGH     = 5'h06;
  localparam logic [4:0] OFS_ZLOW      = 5'h07;
  localparam logic [4:0] OFS_ZHIGH     = 5'h08;
  localparam logic [4:0] OFS_STATUS2   = 5'h09;
  localparam logic [4:0] OFS_CONTROL1  = 5'h0a;
  localparam logic [4:0] OFS_CONTROL2  = 5'h0b;
  localparam logic [4:0] OFS_SELFTEST  = 5'h0c;
  localparam logic [4:0] OFS_FTEST_A   = 5'h0d;
  localparam logic [4:0] OFS_FTEST_B   = 5'h0e;
  localparam logic [4:0] OFS_PORT_DIS  = 5'h0f;
  localparam logic [4:0] OFS_XTRIM     = 5'h10;
  localparam logic [4:0] OFS_YTRIM     = 5'h11;
  localparam logic [4:0] OFS_ZTRIM     = 5'h12;

  // field positions
  localparam int RDY_BIT   = 0;
  localparam int SKIP_BIT  = 1;
  localparam int OVF_BIT   = 3;
  localparam int WIDTH_BIT = 4;
  localparam int SOFT_RESET_BIT = 0;
  localparam int SELFTEST_BIT   = 6;
  localparam int MODE_MSB  = 3;

  localparam logic [7:0] BYTE_RESET   = 8'h00;
  localparam logic [7:0] PORT_DIS_KEY = 8'h1b;

  // operating mode codes
  localparam logic [3:0] MODE_OFF    = 4'h0;
  localparam logic [3:0] MODE_SINGLE = 4'h1;
  localparam logic [3:0] MODE_CONT1  = 4'h2;
  localparam logic [3:0] MODE_CONT2  = 4'h6;
  localparam logic [3:0] MODE_TRIG   = 4'h4;
  localparam logic [3:0] MODE_SELF   = 4'h8;
  localparam logic [3:0] MODE_FUSE   = 4'hf;

  // output limits, 16-bit and 14-bit settings
  localparam logic signed [15:0] MAX_16 = 16'sh7ff8;
  localparam logic signed [15:0] MIN_16 = 16'sh8008;
  localparam logic signed [15:0] MAX_14 = 16'sh1ffe;
  localparam logic signed [15:0] MIN_14 = 16'she002;

  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
    logic        overflow;
  } meas_s;

endpackage

// File: testbench/mag_readout_chk.sv
// port-level relations of the magnetometer readout.
// assumes one clock domain; bound onto every mag_readout instance.
`timescale 1ns/10ps
module mag_readout_chk #(
  parameter logic [7:0] IDENTITY = 8'h5a
) (
  input wire logic                   ref_clk,
  input wire logic                   rstn,
  input wire logic [4:0]             reg_addr,
  input wire logic                   reg_wr,
  input wire logic                   reg_rd,
  input wire logic [7:0]             reg_wdata,
  input wire logic [7:0]             reg_rdata,
  input wire logic                   reg_rvalid,
  input wire logic                   meas_begin,
  input wire logic                   meas_done,
  input wire mag_readout_pkg::meas_s meas_in,
  input wire logic [3:0]             op_mode,
  input wire logic                   wide_output,
  input wire logic                   selftest_on
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  wire rd_s1 = reg_rd && reg_addr == 5'h02;
  wire rd_s2 = reg_rd && reg_addr == 5'h09;
  wire rd_dat = reg_rd && reg_addr >= 5'h03 && reg_addr <= 5'h08;
  wire wr_c1 = reg_wr && reg_addr == 5'h0a;
  // same-cycle result would win, so it is excluded
  sequence s_drain;
    rd_dat && !meas_done ##1 rd_s1;
  endsequence
  sequence s_ctl_s1;
    wr_c1 ##1 rd_s1;
  endsequence
  sequence s_beg_s2;
    meas_begin && !meas_done ##1 rd_s2;
  endsequence
  property p_ident;
    reg_rd && reg_addr == 5'h00 |=> reg_rvalid && reg_rdata == IDENTITY;
  endproperty
  property p_s1_pad;
    rd_s1 |=> reg_rvalid && reg_rdata[7:2] == 6'h00;
  endproperty
  property p_mirror;
    rd_s2 |=> reg_rdata == {3'h0, $past(wide_output), reg_rdata[3], 3'h0};
  endproperty
  property p_mode;
    wr_c1 |=> op_mode == $past(reg_wdata[3:0])
      && wide_output == $past(reg_wdata[4]);
  endproperty
  property p_drain;
    s_drain |=> reg_rdata[1:0] == 2'h0;
  endproperty
  property p_ctl;
    s_ctl_s1 |=> reg_rdata == 8'h00;
  endproperty
  property p_ovf;
    s_beg_s2 |=> !reg_rdata[3];
  endproperty
  property p_soft_reset_bit;
    reg_wr && reg_addr == 5'h0b && reg_wdata[0]
      |=> op_mode == 4'h0 && !wide_output && !selftest_on;
  endproperty
  a_ident: assert property (p_ident) else $error("identity wrong");
  a_s1_pad: assert property (p_s1_pad) else $error("status pad");
  a_mirror: assert property (p_mirror) else $error("width mirror");
  a_mode: assert property (p_mode) else $error("mode field");
  a_drain: assert property (p_drain) else $error("flags kept");
  a_ctl: assert property (p_ctl) else $error("status kept");
  a_ovf: assert property (p_ovf) else $error("overflow kept");
  a_soft_reset_bit: assert property (p_soft_reset_bit) else $error("soft reset");
endmodule // mag_readout_chk

bind mag_readout mag_readout_chk #(.IDENTITY(IDENTITY)) i_chk (
  .ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .meas_begin(meas_begin),
  .meas_done(meas_done), .meas_in(meas_in), .op_mode(op_mode),
  .wide_output(wide_output), .selftest_on(selftest_on));

// File: testbench/mag_host.sv
// host model driving the register port of the readout block.
// assumes the bench calls op once per clock edge.
`timescale 1ns/10ps
module mag_host (
  // clock
  input  wire logic       ref_clk,
  // register port
  output logic      [4:0] reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_wdata
);
  initial begin
    reg_addr = 5'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // idle bus inverts, so a stale value never looks valid
  task automatic op(input logic w, input logic r,
                    input logic [4:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    if (a == 5'h0d || a == 5'h0e) begin
      w = 1'b0;
      r = 1'b0;
    end
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= (w | r) ? a : ~reg_addr;
    reg_wdata <= w ? d : ~reg_wdata;
  endtask
endmodule // mag_host

// File: testbench/magnetometer_register_readout_tb.sv
// self-checking bench for the magnetometer readout block.
// assumes mag_host on the register port; bench drives the front end.
`timescale 1ns/10ps
module magnetometer_register_readout_tb;
  logic                   ref_clk;
  logic                   rstn;
  logic [4:0]             reg_addr;
  logic                   reg_wr;
  logic                   reg_rd;
  logic [7:0]             reg_wdata;
  logic [7:0]             reg_rdata;
  logic                   reg_rvalid;
  logic                   meas_begin;
  logic                   meas_done;
  mag_readout_pkg::meas_s meas_in;
  logic [7:0]             exp_q[$];
  logic [15:0]            v[3];
  logic [15:0]            c;
  logic [7:0]             exp_b;
  logic [3:0]             modes[7] = '{4'h0, 4'h1, 4'h2, 4'h6, 4'h4,
                                       4'h8, 4'hf};
  int                     fails;
  int                     checks;
  int                     cyc;

  mag_host i_host (.ref_clk(ref_clk), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));
  mag_readout i_dut (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .meas_begin(meas_begin), .meas_done(meas_done), .meas_in(meas_in),
    .op_mode(), .wide_output(), .selftest_on());

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  function automatic logic [15:0] clamp(logic [15:0] x, logic w);
    logic signed [15:0] hi;
    hi = w ? 16'sh7ff8 : 16'sh1ffe;
    if ($signed(x) > hi) return hi;
    if ($signed(x) < -hi) return -hi;
    return x;
  endfunction
  task automatic test_done;
    $display("fails=%0d checks=%0d", fails, checks);
    if (fails == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_host.op(1'b0, 1'b1, a, 8'h00);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    i_host.op(1'b1, 1'b0, a, d);
  endtask
  task automatic res(input logic o);
    i_host.op(1'b0, 1'b0, 5'h00, 8'h00);
    meas_done <= 1'b1;
    meas_in <= {v[0], v[1], v[2], o};
    @(posedge ref_clk);
    meas_done <= 1'b0;
    meas_in <= ~meas_in;
  endtask
  task automatic fin(input string s);
    i_host.op(1'b0, 1'b0, 5'h00, 8'h00);
    $display("test %s done", s);
  endtask
  // result checker: oldest note against each returned byte
  always @(negedge ref_clk) begin
    cyc++;
    if (reg_rvalid === 1'b1) begin
      exp_b = exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx;
      checks++;
      if (reg_rdata !== exp_b) begin
        fails++;
        $display("ERROR t=%0t exp=%h got=%h", $time, exp_b, reg_rdata);
      end
    end
    if (cyc == 3000) begin
      fails++;
      test_done();
    end
  end
  initial begin
    rstn = 1'b0;
    meas_begin = 1'b0;
    meas_done = 1'b0;
    meas_in = '0;
    fails = 0;
    checks = 0;
    cyc = 0;
    void'($urandom(32'h7677));
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    wr(5'h00, 8'hff);
    rd(5'h00, 8'h5a);
    rd(5'h1f, 8'h00);
    for (int a = 1; a <= 18; a++)
      if (a != 13 && a != 14) rd(5'(a), 8'h00);
    fin("reset");
    foreach (modes[i]) begin
      wr(5'h0a, {3'h0, i[0], modes[i]});
      rd(5'h0a, {3'h0, i[0], modes[i]});
      rd(5'h09, {3'h0, i[0], 4'h0});
    end
    rd(5'h10, 8'h80);
    fin("modes");
    for (int i = 0; i < 4; i++) begin
      foreach (v[k]) v[k] = 16'($urandom);
      if (i[0]) v[0] = 16'h7fff;
      if (i == 2) v[1] = 16'h8000;
      wr(5'h0a, {3'h0, i[1], i[0] ? 4'h8 : 4'h1});
      res(1'b0);
      rd(5'h02, 8'h01);
      foreach (v[k]) begin
        c = clamp(v[k], i[1]);
        rd(5'(3 + 2 * k), c[7:0]);
        rd(5'(4 + 2 * k), c[15:8]);
      end
      rd(5'h02, 8'h00);
      rd(5'h09, {3'h0, i[1], 4'h0});
    end
    fin("single");
    wr(5'h0a, 8'h12);
    v = '{16'h1234, 16'h0042, 16'h0007};
    res(1'b0);
    rd(5'h03, 8'h34);
    v[0] = 16'h5678;
    res(1'b0);
    rd(5'h02, 8'h02);
    rd(5'h04, 8'h12);
    rd(5'h02, 8'h00);
    rd(5'h09, 8'h10);
    res(1'b0);
    rd(5'h03, 8'h78);
    rd(5'h09, 8'h10);
    fin("session");
    wr(5'h0a, 8'h11);
    res(1'b1);
    rd(5'h09, 8'h18);
    i_host.op(1'b0, 1'b0, 5'h00, 8'h00);
    meas_begin <= 1'b1;
    rd(5'h09, 8'h10);
    meas_begin <= 1'b0;
    res(1'b0);
    wr(5'h0a, 8'h11);
    for (int a = 2; a <= 9; a++) rd(5'(a), a == 9 ? 8'h10 : 8'h00);
    fin("overflow");
    wr(5'h0c, 8'h40);
    rd(5'h0c, 8'h40);
    wr(5'h0b, 8'h01);
    rd(5'h0a, 8'h00);
    rd(5'h0b, 8'h00);
    rd(5'h0c, 8'h00);
    fin("soft reset");
    repeat (3) @(posedge ref_clk);
    if (exp_q.size() != 0) fails++;
    test_done();
  end
endmodule // magnetometer_register_readout_tb
